/* inc/audio_link_pkg.sv */
// package: register map, field positions, reset values and bus types of the audio/link block
//
// Notes on behaviour
// - config bit 7 set enables the tdm-to-parallel audio converter
// - while converting, downstream audio is timed by the converter's clock
// - config bit 6 set drives recovered hdmi audio onto the i2s pins
// - the local hdmi output enable is ignored unless audio source selects hdmi (00)
// - config bit 3 set resets the audio fifo on audio type change
// - config bit 2 set resets the audio fifo on audio infoframe checksum change
// - config bit 1 set resets the audio fifo on video infoframe checksum change
// - config bit 0 set resets the audio fifo on n or cts change
// - status bit 7 shows downstream connection found and capabilities known
// - status bit 6 shows transmitter active and far receiver locked
// - transmit status only after valid input and correct single/dual mode
// - audio source 0 sends hdmi audio, 1 sends local i2s pin audio
// - with transmit status set, two-bit port mode field reports 01 single port 0
package audio_link_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_AUDIO_CONFIGURATION = 8'h55;
  localparam logic [7:0] IDX_SERIAL_LINK_STATUS = 8'h5a;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
  localparam logic [7:0] IDX_BRIDGE_CONTROL = 8'h62;
  localparam int ADDR_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // audio configuration fields
  localparam int CFG_TDM_TO_PARALLEL = 7;
  localparam int CFG_HDMI_I2S_OUT = 6;
  localparam int CFG_RST_ON_TYPE = 3;
  localparam int CFG_RST_ON_AUDIO_IF = 2;
  localparam int CFG_RST_ON_VIDEO_IF = 1;
  localparam int CFG_RST_ON_CLOCK_REGEN = 0;
  localparam logic [7:0] CFG_RESET = 8'h0c;
  localparam logic [7:0] CFG_WRITABLE = 8'hcf; // bits 5:4 reserved, read zero

  ////////////////////////////////////////////////////////////////////////////
  // serial link status fields
  localparam int STS_LINK_READY = 7;
  localparam int STS_TX_LOCKED = 6;
  localparam int STS_PORT_MODE_LO = 4;
  localparam logic [1:0] PORT_MODE_SINGLE_P0 = 2'h1;
  localparam logic [7:0] STS_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // bridge control (audio source) and interrupt status layout
  localparam logic [1:0] AUDIO_SRC_HDMI = 2'h0;
  localparam logic [1:0] AUDIO_SRC_LOCAL = 2'h1;
  localparam logic [1:0] BRIDGE_RESET = 2'h0;
  localparam int IRQ_W = 4;
  localparam int IRQ_FIFO_RESET = 0;
  localparam int IRQ_LINK_READY = 1;
  localparam int IRQ_TX_LOCKED = 2;
  localparam int IRQ_LINK_LOST = 3;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // observed hdmi side-band fields
  typedef struct packed {
    logic [3:0] audio_type;
    logic [7:0] audio_if_sum;
    logic [7:0] video_if_sum;
    logic [19:0] acr_n;
    logic [19:0] acr_cts;
  } hdmi_info_t;

  // link condition inputs
  typedef struct packed {
    logic connection_found;
    logic caps_known;
    logic tx_active;
    logic far_locked;
    logic input_valid;
    logic mode_correct;
  } link_cond_t;

  // one audio sample word with its valid strobe
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } audio_word_t;

endpackage

/* src/audio_change_detect.sv */
// audio side-band change detector producing the fifo reset pulse
`timescale 1ns/100ps
`default_nettype none
module audio_change_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // observed fields and enables
  input wire audio_link_pkg::hdmi_info_t info,
  input wire logic info_valid,
  input wire logic [3:0] reset_enable,
  // result
  output logic fifo_reset
);
  import audio_link_pkg::*;

  hdmi_info_t last;
  logic primed;
  logic [3:0] changed;

  // per-field mismatch against the stored copy, index matches config bit
  always_comb begin
    changed[CFG_RST_ON_TYPE] = last.audio_type != info.audio_type;
    changed[CFG_RST_ON_AUDIO_IF] = last.audio_if_sum != info.audio_if_sum;
    changed[CFG_RST_ON_VIDEO_IF] = last.video_if_sum != info.video_if_sum;
    changed[CFG_RST_ON_CLOCK_REGEN] = (last.acr_n != info.acr_n) ||
                                      (last.acr_cts != info.acr_cts);
  end

  // first valid sample only primes the copy, since there is no earlier value to differ from
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last <= '0;
      primed <= 1'b0;
      fifo_reset <= 1'b0;
    end else begin
      fifo_reset <= info_valid && primed && |(changed & reset_enable);
      if (info_valid) begin
        last <= info;
        primed <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* src/audio_link_regs.sv */
// audio configuration and serial link status registers behind an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
module audio_link_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [audio_link_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [audio_link_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // hdmi side-band observations
  input wire audio_link_pkg::hdmi_info_t hdmi_info,
  input wire logic hdmi_info_valid,
  // audio streams
  input wire audio_link_pkg::audio_word_t hdmi_audio,
  input wire audio_link_pkg::audio_word_t local_audio,
  input wire audio_link_pkg::audio_word_t tdm_audio,
  input wire logic tdm_clock_tick,
  input wire logic hdmi_clock_tick,
  // link conditions from the serializer, asynchronous
  input wire audio_link_pkg::link_cond_t link_cond,
  // outputs
  output logic tdm_convert_enable,
  output audio_link_pkg::audio_word_t downstream_audio,
  output logic downstream_audio_tick,
  output audio_link_pkg::audio_word_t i2s_out,
  output logic i2s_out_enable,
  output logic audio_fifo_reset,
  output logic irq
);
  import audio_link_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and local signals
  logic [7:0] audio_configuration;
  logic [7:0] serial_link_status;
  logic [1:0] audio_source;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  link_cond_t cond_meta;
  link_cond_t cond_sync;
  logic downstream_link_ready;
  logic transmitter_locked_status;
  logic [1:0] link_port_mode_status;
  logic prev_ready;
  logic prev_locked;
  logic fifo_reset_pulse;
  logic [IRQ_W-1:0] irq_event;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic [31:0] next_rdata;
  logic next_rresp_err;

  // word index from a byte address; low two bits ignored
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[ADDR_W-1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link condition synchroniser, two flops before any logic reads it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_meta <= '0;
      cond_sync <= '0;
    end else begin
      cond_meta <= link_cond;
      cond_sync <= cond_meta;
    end
  end

  // link status bits; tx status gated by valid input and correct mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      downstream_link_ready <= 1'b0;
      transmitter_locked_status <= 1'b0;
      link_port_mode_status <= 2'h0;
    end else begin
      downstream_link_ready <= cond_sync.connection_found && cond_sync.caps_known;
      transmitter_locked_status <= cond_sync.tx_active && cond_sync.far_locked &&
                                   cond_sync.input_valid && cond_sync.mode_correct;
      // port mode only meaningful while transmitting; single port 0 is the only mode
      link_port_mode_status <= (cond_sync.tx_active && cond_sync.far_locked &&
                                cond_sync.input_valid && cond_sync.mode_correct) ?
                               PORT_MODE_SINGLE_P0 : 2'h0;
    end
  end

  always_comb begin
    serial_link_status = STS_RESET;
    serial_link_status[STS_LINK_READY] = downstream_link_ready;
    serial_link_status[STS_TX_LOCKED] = transmitter_locked_status;
    serial_link_status[STS_PORT_MODE_LO +: 2] = link_port_mode_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo reset source
  audio_change_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .info(hdmi_info),
    .info_valid(hdmi_info_valid),
    .reset_enable(audio_configuration[3:0]),
    .fifo_reset(fifo_reset_pulse)
  );
  assign audio_fifo_reset = fifo_reset_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // audio routing
  assign tdm_convert_enable = audio_configuration[CFG_TDM_TO_PARALLEL];

  // downstream source and timing; registered so data outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      downstream_audio <= '0;
      downstream_audio_tick <= 1'b0;
    end else begin
      if (audio_configuration[CFG_TDM_TO_PARALLEL]) begin
        downstream_audio <= tdm_audio;
        downstream_audio_tick <= tdm_clock_tick;
      end else begin
        downstream_audio <= (audio_source == AUDIO_SRC_HDMI) ? hdmi_audio : local_audio;
        downstream_audio_tick <= hdmi_clock_tick;
      end
    end
  end

  // local i2s output only when hdmi is the audio source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i2s_out <= '0;
      i2s_out_enable <= 1'b0;
    end else begin
      i2s_out_enable <= audio_configuration[CFG_HDMI_I2S_OUT] &&
                        (audio_source == AUDIO_SRC_HDMI);
      i2s_out <= (audio_configuration[CFG_HDMI_I2S_OUT] && (audio_source == AUDIO_SRC_HDMI)) ?
                 hdmi_audio : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // read-only status and unmapped words answer slverr
        case (word_index(aw_addr))
          IDX_AUDIO_CONFIGURATION, IDX_IRQ_STATUS, IDX_IRQ_MASK,
          IDX_BRIDGE_CONTROL: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software-written registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      audio_configuration <= CFG_RESET;
      audio_source <= BRIDGE_RESET;
      irq_mask <= '0;
    end else if (do_write && w_strb[0]) begin
      case (word_index(aw_addr))
        IDX_AUDIO_CONFIGURATION: audio_configuration <= w_data[7:0] & CFG_WRITABLE;
        IDX_BRIDGE_CONTROL: audio_source <= w_data[1:0];
        IDX_IRQ_MASK: irq_mask <= w_data[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events: fifo reset, link ready rise, lock rise, lock loss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ready <= 1'b0;
      prev_locked <= 1'b0;
    end else begin
      prev_ready <= downstream_link_ready;
      prev_locked <= transmitter_locked_status;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[IRQ_FIFO_RESET] = fifo_reset_pulse;
    irq_event[IRQ_LINK_READY] = downstream_link_ready && !prev_ready;
    irq_event[IRQ_TX_LOCKED] = transmitter_locked_status && !prev_locked;
    irq_event[IRQ_LINK_LOST] = !transmitter_locked_status && prev_locked;
  end

  // write-one-to-clear; a new event in the clearing cycle wins so none is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      if (do_write && w_strb[0] && word_index(aw_addr) == IDX_IRQ_STATUS) begin
        irq_status <= (irq_status & ~w_data[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel: one read at a time, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rdata = '0;
    next_rresp_err = 1'b0;
    case (word_index(s_axi_araddr))
      IDX_AUDIO_CONFIGURATION: next_rdata[7:0] = audio_configuration;
      IDX_SERIAL_LINK_STATUS: next_rdata[7:0] = serial_link_status;
      IDX_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      IDX_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      IDX_BRIDGE_CONTROL: next_rdata[1:0] = audio_source;
      default: next_rresp_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sim/audio_link_chk.sv */
// checker: port-level properties of the audio/link register block
`timescale 1ns/100ps
`default_nettype none
module audio_link_chk (
  // clock, reset and bus answers
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // side-band and audio inputs
  input wire audio_link_pkg::hdmi_info_t hdmi_info,
  input wire logic hdmi_info_valid,
  input wire audio_link_pkg::audio_word_t hdmi_audio,
  input wire audio_link_pkg::audio_word_t tdm_audio,
  input wire logic tdm_clock_tick,
  input wire logic hdmi_clock_tick,
  // outputs watched
  input wire logic tdm_convert_enable,
  input wire audio_link_pkg::audio_word_t downstream_audio,
  input wire logic downstream_audio_tick,
  input wire audio_link_pkg::audio_word_t i2s_out,
  input wire logic i2s_out_enable,
  input wire logic audio_fifo_reset
);
  import audio_link_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  hdmi_info_t last_info;
  logic primed;
  logic changed;
  ////////////////////////////////////////////////////////////////////////////
  // own copy of the last valid side-band; the first valid after reset only primes
  always_ff @(posedge aclk) begin
    if (!aresetn) primed <= 1'b0;
    else if (hdmi_info_valid) primed <= 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (hdmi_info_valid) last_info <= hdmi_info;
  end
  assign changed = hdmi_info_valid && primed && (hdmi_info != last_info);
  ////////////////////////////////////////////////////////////////////////////
  a_tdm_data_path: assert property (
    tdm_convert_enable |=> downstream_audio == $past(tdm_audio)
      && downstream_audio_tick == $past(tdm_clock_tick))
    else $error("downstream audio not from converter");
  a_hdmi_tick_path: assert property (
    !tdm_convert_enable |=> downstream_audio_tick == $past(hdmi_clock_tick))
    else $error("downstream tick not from hdmi clock");
  a_i2s_data_copy: assert property (
    i2s_out_enable |-> i2s_out == $past(hdmi_audio))
    else $error("i2s pins not carrying hdmi audio");
  a_i2s_off_quiet: assert property (!i2s_out_enable |-> i2s_out == '0)
    else $error("i2s pins driven while disabled");
  a_i2s_hdmi_only: assert property (
    i2s_out_enable && !$past(tdm_convert_enable) |-> downstream_audio == $past(hdmi_audio))
    else $error("i2s enabled while source not hdmi");
  a_fifo_reset_cause: assert property (audio_fifo_reset |-> $past(changed))
    else $error("fifo reset without a field change");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule
`default_nettype wire

/* sim/link_partner.sv */
// far-side model: link discovery and lock, plus the tdm converter feed
`timescale 1ns/100ps
`default_nettype none
module link_partner (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench requests
  input wire logic connect,
  input wire logic lock,
  input wire logic mode_ok,
  // far-side conditions and converter output
  output var audio_link_pkg::link_cond_t link_cond,
  output var audio_link_pkg::audio_word_t tdm_audio,
  output logic tdm_clock_tick
);
  import audio_link_pkg::*;
  logic [2:0] disc;
  logic [1:0] div;
  ////////////////////////////////////////////////////////////////////////////
  // discovery is slow: the connection shows first, capabilities later, lock last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disc <= 3'h0;
      link_cond <= '0;
    end else begin
      disc <= connect ? disc + {2'h0, disc != 3'h7} : 3'h0;
      link_cond.connection_found <= connect;
      link_cond.caps_known <= connect && disc == 3'h7;
      link_cond.tx_active <= lock && link_cond.caps_known;
      link_cond.far_locked <= lock && link_cond.tx_active;
      link_cond.input_valid <= mode_ok;
      link_cond.mode_correct <= mode_ok && lock;
    end
  end
  // converter ticks every fourth cycle; its data lines never hold a value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 2'h0;
      tdm_audio <= '0;
    end else begin
      div <= div + 2'h1;
      tdm_audio.valid <= div == 2'h3;
      tdm_audio.data <= ~tdm_audio.data;
    end
  end
  assign tdm_clock_tick = tdm_audio.valid;
endmodule
`default_nettype wire

/* sim/tb_audio_fifo_reset_and_link_status.sv */
// bench for the audio/link block: bus, fifo reset events, audio routing, link status
`timescale 1ns/100ps
`default_nettype none
module tb_audio_fifo_reset_and_link_status;
  import audio_link_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, connect = 1'b0, lock = 1'b0, mode_ok = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hdmi_info_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h1d, r;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  hdmi_info_t hdmi_info = '0;
  logic hdmi_clock_tick = 1'b0, tdm_clock_tick, tdm_convert_enable, downstream_audio_tick;
  logic i2s_out_enable, audio_fifo_reset, irq;
  audio_word_t hdmi_audio = '0, local_audio = '0, prev_local, tdm_audio, downstream_audio, i2s_out;
  link_cond_t link_cond;
  int fail_count = 0, n_tests = 0, i, b, f, pulses;
  audio_link_regs dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .hdmi_info, .hdmi_info_valid, .hdmi_audio, .local_audio, .tdm_audio,
    .tdm_clock_tick, .hdmi_clock_tick, .link_cond, .tdm_convert_enable, .downstream_audio,
    .downstream_audio_tick, .i2s_out, .i2s_out_enable, .audio_fifo_reset, .irq);
  link_partner partner (.aclk, .aresetn, .connect, .lock, .mode_ok, .link_cond, .tdm_audio,
    .tdm_clock_tick);
  always #20 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // one field of the side-band moves; n and cts take turns at random
  function automatic hdmi_info_t bump(input hdmi_info_t v, input int fld);
    case (fld)
      0: v.audio_type = v.audio_type + 4'h1;
      1: v.audio_if_sum = v.audio_if_sum + 8'h1;
      2: v.video_if_sum = v.video_if_sum + 8'h1;
      default: v.acr_n = v.acr_n + {19'h0, seed[0]};
    endcase
    if (fld == 3 && !seed[0]) v.acr_cts = v.acr_cts + 20'h1;
    return v;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bready rises with the request and stays up until bvalid is sampled, so each
  // ready line is written once per edge and the response is taken where it stands
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!s_axi_bvalid && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (n >= 50) begin
      chk("write answer", 1, 0);
      complete_run();
    end else begin
      chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
    end
  endtask
  task automatic axi_rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!s_axi_rvalid && n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (n >= 50) begin
      chk("read answer", 1, 0);
      complete_run();
    end else begin
      chk("read data", {24'h0, ed}, s_axi_rdata);
      chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
    end
  endtask
  // one valid side-band cycle, then count reset pulses over the next four cycles
  task automatic send_info(input hdmi_info_t v);
    @(posedge aclk);
    hdmi_info <= v;
    hdmi_info_valid <= 1'b1;
    @(posedge aclk);
    hdmi_info_valid <= 1'b0;
    pulses = 0;
    repeat (4) begin
      @(posedge aclk);
      if (audio_fifo_reset === 1'b1) pulses++;
    end
  endtask
  // random streams start after reset so no stale tick comes out of it
  always @(posedge aclk) begin
    prev_local <= local_audio;
    if (aresetn) begin
      hdmi_audio <= {1'b1, rnd()};
      local_audio <= {1'b1, rnd()};
      hdmi_clock_tick <= seed[3];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(IDX_AUDIO_CONFIGURATION, CFG_RESET, RESP_OKAY);
    axi_rd(IDX_BRIDGE_CONTROL, {6'h0, AUDIO_SRC_HDMI}, RESP_OKAY);
    axi_wr(IDX_SERIAL_LINK_STATUS, 8'hff, RESP_SLVERR);
    axi_rd(IDX_SERIAL_LINK_STATUS, STS_RESET, RESP_OKAY);
    axi_rd(8'h70, 8'h00, RESP_SLVERR);
    for (i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'hff : rnd();
      axi_wr(IDX_AUDIO_CONFIGURATION, r[7:0], RESP_OKAY);
      chk("convert enable", {31'h0, r[7]}, {31'h0, tdm_convert_enable});
      axi_rd(IDX_AUDIO_CONFIGURATION, r[7:0] & CFG_WRITABLE, RESP_OKAY);
    end
    // each enable alone while every field moves in turn; first valid only primes
    axi_wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    send_info(bump(hdmi_info, 1));
    chk("priming pulses", 0, pulses);
    for (b = 0; b < 4; b++) begin
      axi_wr(IDX_AUDIO_CONFIGURATION, 8'h01 << b, RESP_OKAY);
      for (f = 0; f < 4; f++) begin
        send_info(bump(hdmi_info, f));
        chk("fifo reset pulses", (b == 3 - f) ? 1 : 0, pulses);
      end
    end
    chk("irq raised", 1, {31'h0, irq});
    axi_wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    chk("irq cleared", 0, {31'h0, irq});
    axi_wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    send_info(bump(hdmi_info, 0));
    chk("irq masked", 0, {31'h0, irq});
    axi_rd(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    axi_wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    // local i2s output only with hdmi source; a local source feeds the link instead
    axi_wr(IDX_AUDIO_CONFIGURATION, 8'h40, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("i2s enable", 1, {31'h0, i2s_out_enable});
    axi_wr(IDX_BRIDGE_CONTROL, {6'h0, AUDIO_SRC_LOCAL}, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("i2s enable", 0, {31'h0, i2s_out_enable});
    chk("local audio", prev_local.data, downstream_audio.data);
    axi_wr(IDX_BRIDGE_CONTROL, 8'h00, RESP_OKAY);
    axi_wr(IDX_AUDIO_CONFIGURATION, 8'hc0, RESP_OKAY);
    repeat (20) @(posedge aclk);
    // link comes up in steps; the lock bit waits for valid input and the right mode
    connect <= 1'b1;
    repeat (16) @(posedge aclk);
    axi_rd(IDX_SERIAL_LINK_STATUS, 8'h80, RESP_OKAY);
    lock <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(IDX_SERIAL_LINK_STATUS, 8'h80, RESP_OKAY);
    mode_ok <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(IDX_SERIAL_LINK_STATUS, {2'b11, PORT_MODE_SINGLE_P0, 4'h0}, RESP_OKAY);
    lock <= 1'b0;
    repeat (8) @(posedge aclk);
    axi_rd(IDX_SERIAL_LINK_STATUS, 8'h80, RESP_OKAY);
    axi_rd(IDX_IRQ_STATUS, 8'h0e, RESP_OKAY);
    axi_wr(IDX_IRQ_STATUS, 8'h0e, RESP_OKAY);
    axi_rd(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
    complete_run();
  end
endmodule
bind audio_link_regs audio_link_chk chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .hdmi_info, .hdmi_info_valid,
  .hdmi_audio, .tdm_audio, .tdm_clock_tick, .hdmi_clock_tick, .tdm_convert_enable,
  .downstream_audio, .downstream_audio_tick, .i2s_out, .i2s_out_enable, .audio_fifo_reset);
`default_nettype wire
